// ===== pkg/flash_rw_pkg.sv
// Package with register map, field positions, timing and types of the flash rewrite controller.
package flash_rw_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ctrl0_addr = 8'h00;
	localparam logic [7:0] ctrl1_addr = 8'h04;
	localparam logic [7:0] ctrl4_addr = 8'h08;
	localparam logic [7:0] cmd_addr = 8'h0c;

	// ----------------------------------------
	// Control register 0 fields
	// ----------------------------------------
	localparam int ready_bit = 0;
	localparam int cpu_rewrite_enable_bit = 1;
	localparam int low_block_rewrite_enable_bit = 2;
	localparam int flash_stop_bit = 3;
	localparam int program_error_bit = 6;
	localparam int erase_error_bit = 7;

	// ----------------------------------------
	// Control register 1 fields
	// ----------------------------------------
	localparam int irq_rewrite_mode_select_bit = 1;
	localparam int block0_lock_bit = 5;
	localparam int block1_lock_bit = 6;
	localparam int ctrl1_fixed_bit = 7;

	// ----------------------------------------
	// Control register 4 fields
	// ----------------------------------------
	localparam int suspend_enable_bit = 0;
	localparam int erase_suspend_request_bit = 1;
	localparam int program_suspend_request_bit = 2;
	localparam int erase_active_bit = 3;
	localparam int program_active_bit = 4;
	localparam int read_permission_bit = 6;

	// ----------------------------------------
	// Command register fields
	// ----------------------------------------
	localparam int cmd_op_lsb = 0;
	localparam int cmd_block_lsb = 4;
	localparam int cmd_clear_bit = 8;
	localparam logic [1:0] op_program = 2'h1;
	localparam logic [1:0] op_erase = 2'h2;
	localparam logic [3:0] block_zero = 4'h0;
	localparam logic [3:0] block_one = 4'h1;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int clk_period_ps = 4000;
	localparam int suspend_latency_ns = 20;
	localparam int suspend_latency_cycles = (suspend_latency_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
	localparam int program_time_cycles = 64;
	localparam int erase_time_cycles = 512;
	localparam logic [31:0] unmapped_read = 32'h0000_0000;

	typedef enum logic [1:0] {
		op_idle,
		op_prog,
		op_erase_run
	} op_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
	} bus_req_t;

	typedef struct packed {
		logic ready;
		logic erase_active;
		logic program_active;
		logic read_permission;
		logic flash_powered;
		logic flash_access_block;
	} flash_status_t;

endpackage

// ===== rtl/flash_rewrite_suspend_control.sv
// Flash CPU-rewrite sequencer with interrupt-driven suspend, block protection and AHB-Lite registers.
`timescale 1ns/1ps

// Functional notes
// (R1) Software sets rewrite enable before irq mode.
// (R2) Irq mode: no status-register commands used.
// (R3) Irq accepted only after suspend latency.
// (R4) Irq in irq mode sets erase suspend.
// (R5) Clearing erase suspend request resumes erase.
// (R6) Program: irq accepted only after latency.
// (R7) Irq in irq mode sets program suspend.
// (R8) Clearing program suspend request resumes program.
// (R9) Ready low during program, erase, suspends.
// (R10) Commands accepted only with rewrite enabled.
// (R11) Low-block enable zero rejects blocks 0,1.
// (R12) Block lock bits gate blocks 0,1.
// (R13) Flash stop resets controller, blocks access.
// (R14) Flash stop written only from RAM code.
// (R15) Polled mode hang: software sets flash stop.
// (R16) Stop/wait with rewrite off powers flash down.
// (R17) Program error flag marks failed program.
// (R18) Erase error flag marks failed erase.
// (R19) Polled mode: software suspend requests suspend.
// (R20) Erase active flag spans erase and suspend.
// (R21) Program active flag spans program and suspend.
// (R22) Read permission zero while running, one suspended.
module flash_rewrite_suspend_control #(
	parameter int program_cycles = flash_rw_pkg::program_time_cycles,
	parameter int erase_cycles = flash_rw_pkg::erase_time_cycles
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic irq_request,
	input wire logic low_power_entry,
	input wire logic op_fail,
	output flash_rw_pkg::flash_status_t status
);
	import flash_rw_pkg::*;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rd_data_q;
	bus_req_t req;
	logic take;

	assign req.addr = haddr;
	assign req.write = hwrite;
	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_data_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		return a == reg_addr;
	endfunction

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= take && req.write;
			if (take)
				wr_addr_q <= req.addr[7:0];
		end
	end

	logic wr0, wr1, wr4, wrc;
	assign wr0 = wr_pend_q && hit(wr_addr_q, ctrl0_addr);
	assign wr1 = wr_pend_q && hit(wr_addr_q, ctrl1_addr);
	assign wr4 = wr_pend_q && hit(wr_addr_q, ctrl4_addr);
	assign wrc = wr_pend_q && hit(wr_addr_q, cmd_addr);

	// ----------------------------------------
	// Control bits
	// ----------------------------------------
	logic cpu_rewrite_enable_q, low_block_rewrite_enable_q, flash_stop_q;
	logic irq_rewrite_mode_select_q, block0_lock_q, block1_lock_q;
	logic suspend_enable_q, erase_suspend_request_q, program_suspend_request_q;
	logic program_error_flag_q, erase_error_flag_q;
	op_state_t state_q;
	logic [31:0] count_q;
	logic [31:0] latency_q;
	logic auto_suspend;
	logic erase_done, prog_done;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_rewrite_enable_q <= 1'b0;
			low_block_rewrite_enable_q <= 1'b0;
			flash_stop_q <= 1'b0;
		end else if (wr0) begin
			cpu_rewrite_enable_q <= hwdata[cpu_rewrite_enable_bit];
			low_block_rewrite_enable_q <= hwdata[low_block_rewrite_enable_bit] && hwdata[cpu_rewrite_enable_bit];
			flash_stop_q <= hwdata[flash_stop_bit];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_rewrite_mode_select_q <= 1'b0;
			block0_lock_q <= 1'b1;
			block1_lock_q <= 1'b1;
		end else if (wr0 && !hwdata[cpu_rewrite_enable_bit]) begin
			irq_rewrite_mode_select_q <= 1'b0;
		end else if (wr1) begin
			irq_rewrite_mode_select_q <= hwdata[irq_rewrite_mode_select_bit] && cpu_rewrite_enable_q;
			if (cpu_rewrite_enable_q) begin
				block0_lock_q <= hwdata[block0_lock_bit];
				block1_lock_q <= hwdata[block1_lock_bit];
			end
		end
	end

	// ----------------------------------------
	// Command acceptance
	// ----------------------------------------
	logic [1:0] cmd_op;
	logic [3:0] cmd_block;
	logic block_ok, cmd_ok;
	assign cmd_op = hwdata[cmd_op_lsb +: 2];
	assign cmd_block = hwdata[cmd_block_lsb +: 4];

	always_comb begin
		block_ok = 1'b1;
		if (cmd_block == block_zero)
			block_ok = low_block_rewrite_enable_q && !block0_lock_q; // [R11] [R12]
		else if (cmd_block == block_one)
			block_ok = low_block_rewrite_enable_q && !block1_lock_q; // [R11] [R12]
	end

	// [R10]
	assign cmd_ok = wrc && cpu_rewrite_enable_q && !flash_stop_q && state_q == op_idle && block_ok;

	// ----------------------------------------
	// Automatic operation engine
	// ----------------------------------------
	logic suspended;
	assign suspended = (state_q == op_erase_run && erase_suspend_request_q)
		|| (state_q == op_prog && program_suspend_request_q);

	// An interrupt only suspends once the latency after the command has run out.
	assign auto_suspend = irq_rewrite_mode_select_q && suspend_enable_q && irq_request
		&& latency_q == 32'h0000_0000 && state_q != op_idle; // [R3] [R6]

	assign erase_done = state_q == op_erase_run && !erase_suspend_request_q && count_q == 32'h0000_0001;
	assign prog_done = state_q == op_prog && !program_suspend_request_q && count_q == 32'h0000_0001;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= op_idle;
			count_q <= 32'h0000_0000;
			latency_q <= 32'h0000_0000;
		end else if (flash_stop_q && cpu_rewrite_enable_q) begin
			state_q <= op_idle; // [R13]
			count_q <= 32'h0000_0000;
			latency_q <= 32'h0000_0000;
		end else begin
			if (latency_q != 32'h0000_0000)
				latency_q <= latency_q - 32'h0000_0001;
			case (state_q)
				op_idle: begin
					if (cmd_ok && cmd_op == op_program) begin
						state_q <= op_prog;
						count_q <= program_cycles;
						latency_q <= suspend_latency_cycles;
					end else if (cmd_ok && cmd_op == op_erase) begin
						state_q <= op_erase_run;
						count_q <= erase_cycles;
						latency_q <= suspend_latency_cycles;
					end
				end
				op_prog: begin
					if (prog_done)
						state_q <= op_idle;
					else if (!program_suspend_request_q)
						count_q <= count_q - 32'h0000_0001; // [R8]
				end
				op_erase_run: begin
					if (erase_done)
						state_q <= op_idle;
					else if (!erase_suspend_request_q)
						count_q <= count_q - 32'h0000_0001; // [R5]
				end
				default: state_q <= op_idle;
			endcase
		end
	end

	// Hardware set wins over a software clear in the same cycle.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			suspend_enable_q <= 1'b0;
			erase_suspend_request_q <= 1'b0;
			program_suspend_request_q <= 1'b0;
		end else if (flash_stop_q && cpu_rewrite_enable_q) begin
			erase_suspend_request_q <= 1'b0;
			program_suspend_request_q <= 1'b0;
		end else begin
			if (wr4) begin
				suspend_enable_q <= hwdata[suspend_enable_bit];
				erase_suspend_request_q <= hwdata[erase_suspend_request_bit] && hwdata[suspend_enable_bit]; // [R19] [R5]
				program_suspend_request_q <= hwdata[program_suspend_request_bit] && hwdata[suspend_enable_bit]; // [R19] [R8]
			end
			if (auto_suspend && state_q == op_erase_run)
				erase_suspend_request_q <= 1'b1; // [R4]
			if (auto_suspend && state_q == op_prog)
				program_suspend_request_q <= 1'b1; // [R7]
			if (erase_done)
				erase_suspend_request_q <= 1'b0;
			if (prog_done)
				program_suspend_request_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			program_error_flag_q <= 1'b0;
			erase_error_flag_q <= 1'b0;
		end else begin
			// A result that lands with a clear status command wins, so no error is lost.
			if (wrc && hwdata[cmd_clear_bit]) begin
				program_error_flag_q <= 1'b0;
				erase_error_flag_q <= 1'b0;
			end
			if (prog_done)
				program_error_flag_q <= op_fail; // [R17]
			if (erase_done)
				erase_error_flag_q <= op_fail; // [R18]
		end
	end

	// ----------------------------------------
	// Status
	// ----------------------------------------
	assign status.ready = state_q == op_idle; // [R9]
	assign status.erase_active = state_q == op_erase_run; // [R20]
	assign status.program_active = state_q == op_prog; // [R21]
	assign status.read_permission = state_q == op_idle || suspended; // [R22]
	assign status.flash_powered = !(flash_stop_q && cpu_rewrite_enable_q)
		&& !(low_power_entry && !cpu_rewrite_enable_q); // [R16] [R13]
	assign status.flash_access_block = flash_stop_q && cpu_rewrite_enable_q; // [R13]

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_q <= 32'h0000_0000;
		end else if (take && !req.write) begin
			rd_data_q <= unmapped_read;
			if (hit(req.addr[7:0], ctrl0_addr)) begin
				rd_data_q[ready_bit] <= status.ready;
				rd_data_q[cpu_rewrite_enable_bit] <= cpu_rewrite_enable_q;
				rd_data_q[low_block_rewrite_enable_bit] <= low_block_rewrite_enable_q;
				rd_data_q[flash_stop_bit] <= flash_stop_q;
				rd_data_q[program_error_bit] <= program_error_flag_q;
				rd_data_q[erase_error_bit] <= erase_error_flag_q;
			end else if (hit(req.addr[7:0], ctrl1_addr)) begin
				rd_data_q[irq_rewrite_mode_select_bit] <= irq_rewrite_mode_select_q;
				rd_data_q[block0_lock_bit] <= block0_lock_q;
				rd_data_q[block1_lock_bit] <= block1_lock_q;
				rd_data_q[ctrl1_fixed_bit] <= 1'b1;
			end else if (hit(req.addr[7:0], ctrl4_addr)) begin
				rd_data_q[suspend_enable_bit] <= suspend_enable_q;
				rd_data_q[erase_suspend_request_bit] <= erase_suspend_request_q;
				rd_data_q[program_suspend_request_bit] <= program_suspend_request_q;
				rd_data_q[erase_active_bit] <= status.erase_active;
				rd_data_q[program_active_bit] <= status.program_active;
				rd_data_q[read_permission_bit] <= status.read_permission;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// The stop bit wipes the engine in one cycle, so the step checks leave that cycle out.
	logic engine_stop;
	assign engine_stop = flash_stop_q && cpu_rewrite_enable_q;

	sequence cmd_started;
		state_q == op_idle ##1 state_q != op_idle;
	endsequence

	sequence erase_held;
		state_q == op_erase_run && erase_suspend_request_q && !engine_stop;
	endsequence
	sequence prog_held;
		state_q == op_prog && program_suspend_request_q && !engine_stop;
	endsequence
	sequence erase_running;
		state_q == op_erase_run && !erase_suspend_request_q && !erase_done && !engine_stop;
	endsequence
	sequence prog_running;
		state_q == op_prog && !program_suspend_request_q && !prog_done && !engine_stop;
	endsequence

	chk_latency_guard: assert property (@(posedge mclk) disable iff (!reset_n) // [R3] [R6]
		cmd_started ##0 irq_rewrite_mode_select_q
			|-> !(erase_suspend_request_q || program_suspend_request_q) [*5])
		else $error("suspend taken before latency");
	chk_erase_autosus: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
		auto_suspend && state_q == op_erase_run && !flash_stop_q |=> erase_suspend_request_q)
		else $error("erase not suspended by irq");
	chk_prog_autosus: assert property (@(posedge mclk) disable iff (!reset_n) // [R7]
		auto_suspend && state_q == op_prog && !flash_stop_q |=> program_suspend_request_q)
		else $error("program not suspended by irq");
	chk_ready_busy: assert property (@(posedge mclk) disable iff (!reset_n) // [R9]
		status.ready != (status.erase_active || status.program_active))
		else $error("ready flag wrong");
	chk_cmd_gate: assert property (@(posedge mclk) disable iff (!reset_n) // [R10]
		state_q == op_idle && !cpu_rewrite_enable_q |=> state_q == op_idle)
		else $error("command taken with rewrite off");
	chk_lowblk_reject: assert property (@(posedge mclk) disable iff (!reset_n) // [R11]
		wrc && !low_block_rewrite_enable_q && cmd_block == block_zero |=> $stable(state_q))
		else $error("block 0 command accepted");
	chk_stop_resets: assert property (@(posedge mclk) disable iff (!reset_n) // [R13]
		flash_stop_q && cpu_rewrite_enable_q |=> state_q == op_idle)
		else $error("stop did not reset engine");
	chk_read_perm: assert property (@(posedge mclk) disable iff (!reset_n) // [R22]
		state_q == op_erase_run && !erase_suspend_request_q |-> !status.read_permission)
		else $error("read allowed during erase");

	// ----------------------------------------
	// Checks: suspend and resume steps
	// ----------------------------------------
	chk_erase_hold: assert property (@(posedge mclk) disable iff (!reset_n) // [R4] [R19]
		erase_held |=> count_q == $past(count_q))
		else $error("erase ran while suspended");
	chk_erase_resume: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
		erase_running |=> count_q == $past(count_q) - 32'h0000_0001)
		else $error("erase did not advance");
	chk_prog_hold: assert property (@(posedge mclk) disable iff (!reset_n) // [R7] [R19]
		prog_held |=> count_q == $past(count_q))
		else $error("program ran while suspended");
	chk_prog_resume: assert property (@(posedge mclk) disable iff (!reset_n) // [R8]
		prog_running |=> count_q == $past(count_q) - 32'h0000_0001)
		else $error("program did not advance");
	chk_polled_erase_sus: assert property (@(posedge mclk) disable iff (!reset_n) // [R19]
		wr4 && hwdata[suspend_enable_bit] && hwdata[erase_suspend_request_bit] && !erase_done && !engine_stop
			|=> erase_suspend_request_q)
		else $error("software erase suspend lost");
	chk_polled_prog_sus: assert property (@(posedge mclk) disable iff (!reset_n) // [R19]
		wr4 && hwdata[suspend_enable_bit] && hwdata[program_suspend_request_bit] && !prog_done && !engine_stop
			|=> program_suspend_request_q)
		else $error("software program suspend lost");

	// ----------------------------------------
	// Checks: command start, block lock and result flags
	// ----------------------------------------
	chk_erase_start: assert property (@(posedge mclk) disable iff (!reset_n) // [R20] [R9]
		cmd_ok && cmd_op == op_erase |=> status.erase_active && !status.ready)
		else $error("erase did not start");
	chk_prog_start: assert property (@(posedge mclk) disable iff (!reset_n) // [R21] [R9]
		cmd_ok && cmd_op == op_program |=> status.program_active && !status.ready)
		else $error("program did not start");
	chk_prog_error: assert property (@(posedge mclk) disable iff (!reset_n) // [R17]
		prog_done |=> program_error_flag_q == $past(op_fail))
		else $error("program result not recorded");
	chk_erase_error: assert property (@(posedge mclk) disable iff (!reset_n) // [R18]
		erase_done |=> erase_error_flag_q == $past(op_fail))
		else $error("erase result not recorded");
	chk_block1_lock: assert property (@(posedge mclk) disable iff (!reset_n) // [R12]
		wrc && state_q == op_idle && block1_lock_q && cmd_block == block_one |=> state_q == op_idle)
		else $error("locked block 1 command accepted");

endmodule

// ===== verif/testbench.sv
// Self-checking testbench for the flash rewrite suspend controller.
`timescale 1ns/1ps

module testbench;
	import flash_rw_pkg::*;

	// Short operation times keep the suspend holds and completions quick.
	localparam int prog_n = 16;
	localparam int erase_n = 32;

	logic mclk, reset_n, hsel, hwrite, irq_request, low_power_entry, op_fail, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	flash_status_t status;
	int error_cnt, n_tests;

	flash_rewrite_suspend_control #(.program_cycles(prog_n), .erase_cycles(erase_n)) dut_u (
		.mclk(mclk),
		.reset_n(reset_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.irq_request(irq_request),
		.low_power_entry(low_power_entry),
		.op_fail(op_fail),
		.status(status)
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ----------------------------------------
	// Reporting and bus tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// The slave never stretches today, but the bound keeps a stuck bus from hanging the run.
	task automatic wait_hr();
		int i;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t ns: bus ready never came", $time);
			print_verdict();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_hr();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_hr();
		rd = hrdata;
		if (hresp !== 1'b0) begin
			error_cnt++;
			$display("[FAIL] %0t ns: bus error response", $time);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(rd & mask, exp, what);
	endtask

	task automatic wait_ready();
		int i;
		for (i = 0; i < 2000 && status.ready !== 1'b1; i++) begin
			@(posedge mclk);
		end
		if (status.ready !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t ns: operation never finished", $time);
			print_verdict();
		end
	endtask

	function automatic logic [31:0] cmdw(input logic [1:0] op, input logic [3:0] blk);
		return (32'(op) << cmd_op_lsb) | (32'(blk) << cmd_block_lsb);
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdc(ctrl0_addr, 32'hcf, 32'h01, "ctrl0 after reset");
		rdc(ctrl1_addr, 32'hfe, 32'he0, "ctrl1 after reset");
		rdc(ctrl4_addr, 32'h5f, 32'h40, "ctrl4 after reset");
		rdc(8'h10, 32'hffffffff, unmapped_read, "unmapped read");
		check(32'(status.flash_powered), 32'h1, "powered after reset");
		$display("test reset done");
	endtask

	task automatic t_refuse();
		wr(cmd_addr, cmdw(op_program, 4'h2));
		repeat (2) @(posedge mclk);
		check(32'(status.ready), 32'h1, "command taken while rewrite off");
		wr(ctrl0_addr, 32'h02);
		wr(cmd_addr, cmdw(op_erase, block_zero));
		repeat (2) @(posedge mclk);
		check(32'(status.ready), 32'h1, "low block taken while disabled");
		wr(ctrl0_addr, 32'h06);
		wr(cmd_addr, cmdw(op_program, block_one));
		repeat (2) @(posedge mclk);
		check(32'(status.ready), 32'h1, "locked block one taken");
		wr(ctrl1_addr, 32'hc0);
		wr(cmd_addr, cmdw(op_program, block_one));
		repeat (2) @(posedge mclk);
		check(32'(status.ready), 32'h1, "block one taken with own lock set");
		op_fail <= 1'b1;
		wr(cmd_addr, cmdw(op_program, block_zero));
		repeat (2) @(posedge mclk);
		check(32'({status.ready, status.program_active, status.read_permission}), 32'h2, "programming");
		wait_ready();
		op_fail <= 1'b0;
		check(32'(status.program_active), 32'h0, "program active after end");
		rdc(ctrl0_addr, 32'h41, 32'h41, "program error set");
		wr(cmd_addr, 32'h100);
		rdc(ctrl0_addr, 32'h41, 32'h01, "program error cleared");
		wr(ctrl1_addr, 32'he0);
		$display("test refuse done");
	endtask

	task automatic t_suspend(input logic irqmode, input logic [1:0] op, input logic fail);
		logic [31:0] rq, act, err;
		rq = 32'h1 << (op == op_erase ? erase_suspend_request_bit : program_suspend_request_bit);
		act = 32'h1 << (op == op_erase ? erase_active_bit : program_active_bit);
		err = fail ? (32'h1 << (op == op_erase ? erase_error_bit : program_error_bit)) : 32'h0;
		wr(ctrl1_addr, irqmode ? 32'he2 : 32'he0);
		wr(ctrl4_addr, 32'h01);
		op_fail <= fail;
		wr(cmd_addr, cmdw(op, 4'h3));
		if (irqmode) begin
			irq_request <= 1'b1;
			repeat (2) @(posedge mclk);
			check(32'(status.read_permission), 32'h0, "interrupt taken before latency");
		end else begin
			wr(ctrl4_addr, 32'h01 | rq);
		end
		repeat (8) @(posedge mclk);
		irq_request <= 1'b0;
		rdc(ctrl4_addr, 32'h5f, 32'h41 | rq | act, "suspended state");
		repeat (erase_n + 8) @(posedge mclk);
		check(32'({status.ready, status.read_permission}), 32'h1, "held in suspend");
		wr(ctrl4_addr, 32'h01);
		repeat (2) @(posedge mclk);
		check(32'(status.read_permission), 32'h0, "resumed");
		wait_ready();
		op_fail <= 1'b0;
		rdc(ctrl4_addr, 32'h5f, 32'h41, "flags after end");
		rdc(ctrl0_addr, 32'hc1, 32'h01 | err, "error flags");
		wr(cmd_addr, 32'h100);
		$display("test suspend mode %0d op %0d done", irqmode, op);
	endtask

	task automatic t_stop();
		wr(ctrl1_addr, 32'he0);
		wr(ctrl4_addr, 32'h00);
		wr(cmd_addr, cmdw(op_erase, 4'h3));
		repeat (2) @(posedge mclk);
		check(32'(status.erase_active), 32'h1, "erase started");
		wr(ctrl0_addr, 32'h0e);
		repeat (2) @(posedge mclk);
		check(32'({status.ready, status.erase_active, status.flash_powered, status.flash_access_block}), 32'h9,
			"flash stop");
		wr(ctrl0_addr, 32'h06);
		repeat (2) @(posedge mclk);
		check(32'({status.flash_powered, status.flash_access_block}), 32'h2, "flash restarted");
		$display("test stop done");
	endtask

	task automatic t_low_power();
		wr(ctrl1_addr, 32'he2);
		wr(ctrl0_addr, 32'h00);
		rdc(ctrl1_addr, 32'h02, 32'h00, "irq mode cleared with rewrite off");
		low_power_entry <= 1'b1;
		repeat (2) @(posedge mclk);
		check(32'(status.flash_powered), 32'h0, "power off in stop");
		low_power_entry <= 1'b0;
		repeat (2) @(posedge mclk);
		check(32'(status.flash_powered), 32'h1, "power back");
		$display("test low power done");
	endtask

	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		irq_request = 1'b0;
		low_power_entry = 1'b0;
		op_fail = 1'b0;
		reset_n = 1'b0;
		error_cnt = 0;
		n_tests = 0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_refuse();
		t_suspend(1'b0, op_erase, 1'b1);
		t_suspend(1'b0, op_program, 1'b0);
		t_suspend(1'b1, op_program, 1'b0);
		t_suspend(1'b1, op_erase, 1'b0);
		t_stop();
		t_low_power();
		print_verdict();
	end
endmodule
